/* bench/cavc_disp_model.sv */
// display timing partner: retrace pulses, sync sources and a sync monitor
`timescale 1ns/1ps

module cavc_disp_model
(
   input wire logic clk,
   input wire logic line_req,
   input wire logic hsync_out,
   input wire logic vsync_out,
   output logic hretrace,
   output logic hsync_in,
   output logic vsync_in,
   output logic [15:0] sync_seen
);
   // ==========================================
   // idle until the bench asks for a line
   initial
   begin
      hretrace = 1'b0;
      hsync_in = 1'b0;
      vsync_in = 1'b0;
      sync_seen = 16'h0000;
   end

   // one retrace per request, syncs raised with it; each sync output seen high counts once
   always @(posedge clk)
   begin
      hretrace <= #1 line_req;
      hsync_in <= #1 line_req;
      vsync_in <= #1 line_req;
      sync_seen <= sync_seen + {15'h0, hsync_out === 1'b1} + {15'h0, vsync_out === 1'b1};
   end
endmodule

/* bench/testbench.sv */
// self-checking bench for the crt address and vertical blanking block
`timescale 1ns/1ps

module testbench;
   typedef struct packed {logic [7:0] ul; logic [7:0] mc; logic [4:0] rs; logic [15:0] addr; logic ul_on;} cavc_row_s;

   // ==========================================
   // stimulus and observed signals
   logic clk = 1'b0, rst_n = 1'b0, index_we = 1'b0, data_we = 1'b0;
   logic [7:0] wdata = 8'h00, rdata;
   logic extended_select = 1'b0, clocking_mode_dword = 1'b0, max_scan_vbs_bit = 1'b0, overflow_vbs_bit = 1'b0;
   logic char_clk = 1'b0, line_start = 1'b0, frame_start = 1'b0, text_mode = 1'b1, line_req = 1'b0;
   logic [15:0] line_base = 16'h0000, decoder_address_input, sync_seen, seen;
   logic [4:0] row_scan = 5'h00;
   logic hretrace, hsync_in, vsync_in, underline_on, vblank, hsync_out, vsync_out;
   logic [11:0] row_offset;
   logic [13:0] row_offset_bytes;
   int n_errors = 0, n_tests = 0, cycles = 0;
   logic [7:0] reg_idx [8] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h33, 8'h41, 8'h20};
   logic [7:0] reg_max [8] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hEF, 8'h0F, 8'h0F, 8'h00};
   logic [4:0] cnt_exp [4] = '{5'h04, 5'h02, 5'h01, 5'h02};
   // address rows all start from one base, so only the shaping differs
   cavc_row_s rows [9] = '{'{8'h03, 8'h43, 5'h03, 16'h25C3, 1'b1}, '{8'h1F, 8'h03, 5'h1E, 16'h4B87, 1'b0},
      '{8'h00, 8'h23, 5'h00, 16'h4B86, 1'b1}, '{8'h40, 8'h03, 5'h01, 16'h970E, 1'b0},
      '{8'h45, 8'h43, 5'h05, 16'h970E, 1'b1}, '{8'h02, 8'h40, 5'h02, 16'h45C3, 1'b1},
      '{8'h00, 8'h42, 5'h00, 16'h05C3, 1'b1}, '{8'h00, 8'h41, 5'h06, 16'h65C3, 1'b0},
      '{8'h00, 8'h00, 5'h01, 16'h2B87, 1'b0}};

   always #12.5 clk = ~clk;

   cavc_ctrl dut (.clk(clk), .rst_n(rst_n), .index_we(index_we), .data_we(data_we), .wdata(wdata), .rdata(rdata),
      .extended_select(extended_select), .clocking_mode_dword(clocking_mode_dword),
      .max_scan_vbs_bit(max_scan_vbs_bit), .overflow_vbs_bit(overflow_vbs_bit), .char_clk(char_clk),
      .line_start(line_start), .line_base(line_base), .hretrace(hretrace), .frame_start(frame_start),
      .row_scan(row_scan), .text_mode(text_mode), .hsync_in(hsync_in), .vsync_in(vsync_in),
      .row_offset(row_offset), .row_offset_bytes(row_offset_bytes), .decoder_address_input(decoder_address_input),
      .underline_on(underline_on), .vblank(vblank), .hsync_out(hsync_out), .vsync_out(vsync_out));

   cavc_disp_model disp (.clk(clk), .line_req(line_req), .hsync_out(hsync_out), .vsync_out(vsync_out),
      .hretrace(hretrace), .hsync_in(hsync_in), .vsync_in(vsync_in), .sync_seen(sync_seen));

   // ==========================================
   // helpers: every drive lands 1 ns after an edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      index_we = 1'b1;
      wdata = idx;
      tick(1);
      index_we = 1'b0;
      data_we = 1'b1;
      wdata = val;
      tick(1);
      data_we = 1'b0;
   endtask

   // rdata settles one edge after the index is taken
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      index_we = 1'b1;
      wdata = idx;
      tick(1);
      index_we = 1'b0;
      tick(2);
      chk("rdata", {8'h00, exp}, {8'h00, rdata});
   endtask

   // partner pulse needs one edge, the count and blanking both a second
   task automatic vpulse(input int n);
      repeat (n)
      begin
         line_req = 1'b1;
         tick(1);
         line_req = 1'b0;
         tick(3);
      end
   endtask

   task automatic vcase(input int n);
      frame_start = 1'b1;
      tick(1);
      frame_start = 1'b0;
      vpulse(n - 1);
      chk("vblank early", 16'h0000, {15'h0, vblank});
      vpulse(1);
      chk("vblank set", 16'h0001, {15'h0, vblank});
   endtask

   task automatic stop_test;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end

   // ==========================================
   // main sequence
   initial
   begin
      tick(6);
      rst_n = 1'b1;
      tick(1);
      chk("reset address", 16'h0000, decoder_address_input);
      chk("reset syncs", 16'h0000, {14'h0, hsync_out, vsync_out});
      foreach (reg_idx[i]) rd(reg_idx[i], 8'h00);
      foreach (reg_idx[i])
      begin
         wr(reg_idx[i], 8'hFF);
         rd(reg_idx[i], reg_max[i]);
      end
      // data and index in one cycle: data goes to the old unmapped index, 0x16 keeps its value
      index_we = 1'b1;
      data_we = 1'b1;
      wdata = 8'h16;
      tick(1);
      index_we = 1'b0;
      data_we = 1'b0;
      rd(8'h16, 8'hFF);
      // start addresses live outside this block, so only the offset pair is written here
      wr(8'h41, 8'h0A);
      wr(8'h13, 8'h5C);
      for (int e = 0; e < 2; e++)
      begin
         extended_select = e[0];
         clocking_mode_dword = e[0];
         tick(1);
         chk("row offset", 16'h0A5C, {4'h0, row_offset});
         chk("offset bytes", e ? 16'h2970 : 16'h14B8, {2'h0, row_offset_bytes});
      end
      extended_select = 1'b0;
      foreach (rows[i])
      begin
         wr(8'h14, rows[i].ul);
         wr(8'h17, rows[i].mc);
         row_scan = rows[i].rs;
         line_base = 16'h25C3;
         line_start = 1'b1;
         tick(1);
         line_start = 1'b0;
         tick(1);
         chk("address", rows[i].addr, decoder_address_input);
         chk("underline", {15'h0, rows[i].ul_on}, {15'h0, underline_on});
      end
      // underline only in text mode; line 0 matches the field otherwise
      row_scan = 5'h00;
      text_mode = 1'b0;
      tick(1);
      chk("underline graphics", 16'h0000, {15'h0, underline_on});
      text_mode = 1'b1;
      // four character clocks per setting; the count shows the interval
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h14, m[1] ? 8'h20 : 8'h00);
         wr(8'h17, m[0] ? 8'h4B : 8'h43);
         line_base = 16'h0000;
         line_start = 1'b1;
         tick(1);
         line_start = 1'b0;
         repeat (4)
         begin
            char_clk = 1'b1;
            tick(1);
            char_clk = 1'b0;
            tick(1);
         end
         chk("count", {11'h0, cnt_exp[m]}, decoder_address_input);
      end
      wr(8'h17, 8'h00);
      wr(8'h15, 8'h05);
      wr(8'h16, 8'h08);
      vcase(5);
      vpulse(2);
      chk("vblank hold", 16'h0001, {15'h0, vblank});
      vpulse(1);
      chk("vblank end", 16'h0000, {15'h0, vblank});
      overflow_vbs_bit = 1'b1;
      vcase(261);
      overflow_vbs_bit = 1'b0;
      max_scan_vbs_bit = 1'b1;
      vcase(517);
      wr(8'h33, 8'h01);
      extended_select = 1'b1;
      overflow_vbs_bit = 1'b1;
      vcase(261);
      extended_select = 1'b0;
      max_scan_vbs_bit = 1'b0;
      overflow_vbs_bit = 1'b0;
      wr(8'h17, 8'h04);
      vcase(10);
      seen = sync_seen;
      vpulse(3);
      chk("gated syncs", seen, sync_seen);
      wr(8'h17, 8'h80);
      vpulse(3);
      // both syncs high for one cycle per pulse
      chk("running syncs", seen + 16'h0006, sync_seen);
      // mid-run reset with syncs still requested: the run bit must come back clear
      line_req = 1'b1;
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(2);
      chk("mid reset syncs", 16'h0000, {14'h0, hsync_out, vsync_out});
      line_req = 1'b0;
      rd(8'h17, 8'h00);
      stop_test();
   end
endmodule

/* core/cavc_ctrl.sv */
// crt controller address shaping, row offset and vertical blanking
`timescale 1ns/1ps
`include "cavc_defs.svh"

module cavc_ctrl
   import cavc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic index_we,
   input wire logic data_we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic extended_select,
   input wire logic clocking_mode_dword,
   input wire logic max_scan_vbs_bit,
   input wire logic overflow_vbs_bit,
   input wire logic char_clk,
   input wire logic line_start,
   input wire logic [15:0] line_base,
   input wire logic hretrace,
   input wire logic frame_start,
   input wire logic [4:0] row_scan,
   input wire logic text_mode,
   input wire logic hsync_in,
   input wire logic vsync_in,
   output logic [11:0] row_offset,
   output logic [13:0] row_offset_bytes,
   output logic [15:0] decoder_address_input,
   output logic underline_on,
   output logic vblank,
   output logic hsync_out,
   output logic vsync_out
);

   // ==========================================
   // register file
   logic [7:0] index_r;
   logic [7:0] row_offset_low_r;
   logic [7:0] underline_and_count_mode_r;
   logic [7:0] vblank_start_low_r;
   logic [7:0] vblank_end_r;
   logic [7:0] crt_mode_control_r;
   logic [7:0] extended_vblank_start_r;
   logic [7:0] extended_row_offset_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // one-hot write strobes from the current index
   wire wr_off = data_we && index_r == `CAVC_IDX_ROW_OFFSET_LOW;
   wire wr_ul = data_we && index_r == `CAVC_IDX_UNDERLINE_COUNT;
   wire wr_vbs = data_we && index_r == `CAVC_IDX_VBLANK_START_LOW;
   wire wr_vbe = data_we && index_r == `CAVC_IDX_VBLANK_END;
   wire wr_mc = data_we && index_r == `CAVC_IDX_CRT_MODE_CONTROL;
   wire wr_xvbs = data_we && index_r == `CAVC_IDX_EXT_VBLANK_START;
   wire wr_xoff = data_we && index_r == `CAVC_IDX_EXT_ROW_OFFSET;

   // reserved bits are never stored, so they read as zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         index_r <= `CAVC_RST_BYTE;
         row_offset_low_r <= `CAVC_RST_BYTE;
         underline_and_count_mode_r <= `CAVC_RST_BYTE;
         vblank_start_low_r <= `CAVC_RST_BYTE;
         vblank_end_r <= `CAVC_RST_BYTE;
         crt_mode_control_r <= `CAVC_RST_BYTE;
         extended_vblank_start_r <= `CAVC_RST_BYTE;
         extended_row_offset_r <= `CAVC_RST_BYTE;
      end
      else
      begin
         if (index_we)
            index_r <= wdata;
         if (wr_off)
            row_offset_low_r <= wdata;
         if (wr_ul)
            underline_and_count_mode_r <= wdata & `CAVC_UL_RMASK;
         if (wr_vbs)
            vblank_start_low_r <= wdata;
         if (wr_vbe)
            vblank_end_r <= wdata;
         if (wr_mc)
            crt_mode_control_r <= wdata & `CAVC_MC_RMASK;
         if (wr_xvbs)
            extended_vblank_start_r <= wdata & `CAVC_NIB_RMASK;
         if (wr_xoff)
            extended_row_offset_r <= wdata & `CAVC_NIB_RMASK;
      end
   end

   // read mux; unknown indices belong to other blocks and read zero
   always_comb
   begin
      case (index_r)
         `CAVC_IDX_ROW_OFFSET_LOW: rdata_nxt = row_offset_low_r;
         `CAVC_IDX_UNDERLINE_COUNT: rdata_nxt = underline_and_count_mode_r;
         `CAVC_IDX_VBLANK_START_LOW: rdata_nxt = vblank_start_low_r;
         `CAVC_IDX_VBLANK_END: rdata_nxt = vblank_end_r;
         `CAVC_IDX_CRT_MODE_CONTROL: rdata_nxt = crt_mode_control_r;
         `CAVC_IDX_EXT_VBLANK_START: rdata_nxt = extended_vblank_start_r;
         `CAVC_IDX_EXT_ROW_OFFSET: rdata_nxt = extended_row_offset_r;
         default: rdata_nxt = `CAVC_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata_r <= `CAVC_RST_BYTE;
      else
         rdata_r <= rdata_nxt;
   end
   assign rdata = rdata_r;

   // ==========================================
   // row offset, ungated by the extended select
   assign row_offset = {extended_row_offset_r[3:0], row_offset_low_r};
   // byte span of one character row
   assign row_offset_bytes = clocking_mode_dword ? {row_offset, 2'b00}
                                                 : {1'b0, row_offset, 1'b0};

   // ==========================================
   // control bit decode
   wire ul_dword = underline_and_count_mode_r[`CAVC_UL_DWORD];
   wire ul_quarter = underline_and_count_mode_r[`CAVC_UL_QUARTER];
   wire mc_run = crt_mode_control_r[`CAVC_MC_RUN];
   wire mc_byte = crt_mode_control_r[`CAVC_MC_BYTE];
   wire mc_nowrap = crt_mode_control_r[`CAVC_MC_NOWRAP];
   wire mc_half = crt_mode_control_r[`CAVC_MC_HALF];
   wire mc_hrdiv = crt_mode_control_r[`CAVC_MC_HRDIV];
   wire mc_nors1 = crt_mode_control_r[`CAVC_MC_NORS1];
   wire mc_nors0 = crt_mode_control_r[`CAVC_MC_NORS0];

   // doubleword dominates the word/byte bit
   cavc_mode_e mode_w;
   assign mode_w = ul_dword ? CAVC_MODE_DWORD
                 : (mc_byte ? CAVC_MODE_BYTE : CAVC_MODE_WORD);

   // ==========================================
   // memory address counter
   logic [15:0] ma_r;
   logic [1:0] div_r;
   logic [1:0] div_last_w;

   // last divider count: 00 -> 0, 01 -> 1, 10 -> 3, 11 -> 1
   assign div_last_w = (ul_quarter && !mc_half) ? 2'h3
                     : ((ul_quarter || mc_half) ? 2'h1 : 2'h0);
   wire step_w = char_clk && div_r == div_last_w;

   // line start reloads and realigns the cadence
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ma_r <= 16'h0000;
         div_r <= 2'h0;
      end
      else if (line_start)
      begin
         ma_r <= line_base;
         div_r <= 2'h0;
      end
      else if (char_clk)
      begin
         div_r <= step_w ? 2'h0 : div_r + 2'h1;
         if (step_w)
            ma_r <= ma_r + 16'h0001;
      end
   end

   // ==========================================
   // address reorganisation then row scan substitution
   function automatic logic [15:0] cavc_reorg(input logic [15:0] ma, input cavc_mode_e md,
                                              input logic nowrap);
      logic [15:0] o;
      case (md)
         CAVC_MODE_BYTE: o = ma;
         // wrap clear folds bit 13 down for 16 KB wrap
         CAVC_MODE_WORD: o = {ma[14:0], nowrap ? ma[15] : ma[13]};
         CAVC_MODE_DWORD: o = {ma[13:0], ma[13], ma[12]};
         default: o = ma;
      endcase
      return o;
   endfunction

   wire [15:0] reorganised_counter_address = cavc_reorg(ma_r, mode_w, mc_nowrap);
   logic [15:0] addr_nxt;
   always_comb
   begin
      addr_nxt = reorganised_counter_address;
      if (!mc_nors1)
         addr_nxt[14] = row_scan[1];
      if (!mc_nors0)
         addr_nxt[13] = row_scan[0];
   end

   logic [15:0] addr_r;
   logic underline_r;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         addr_r <= 16'h0000;
         underline_r <= 1'b0;
      end
      else
      begin
         addr_r <= addr_nxt;
         underline_r <= text_mode && row_scan == underline_and_count_mode_r[4:0];
      end
   end
   assign decoder_address_input = addr_r;
   assign underline_on = underline_r;

   // ==========================================
   // vertical counter and blanking
   logic [11:0] vcount_r;
   logic hr_phase_r;
   logic vblank_r;
   wire [11:0] vbs_w = extended_select ? {extended_vblank_start_r[3:0], vblank_start_low_r}
                     : {2'b00, max_scan_vbs_bit, overflow_vbs_bit, vblank_start_low_r};
   // half rate: every second retrace pulse advances the counter
   wire vadv_w = hretrace && (!mc_hrdiv || hr_phase_r);
   wire [11:0] vnext_w = vcount_r + 12'h001;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         vcount_r <= 12'h000;
         hr_phase_r <= 1'b0;
         vblank_r <= 1'b0;
      end
      else if (frame_start)
      begin
         vcount_r <= 12'h000;
         hr_phase_r <= 1'b0;
         vblank_r <= vbs_w == 12'h000;
      end
      else if (hretrace)
      begin
         hr_phase_r <= mc_hrdiv ? !hr_phase_r : 1'b0;
         if (vadv_w)
         begin
            vcount_r <= vnext_w;
            // a start match wins over an end match on the same line
            if (vnext_w == vbs_w)
               vblank_r <= 1'b1;
            else if (vnext_w[7:0] == vblank_end_r)
               vblank_r <= 1'b0;
         end
      end
   end
   assign vblank = vblank_r;

   // ==========================================
   // sync gating; nothing else is held by the reset bit
   logic hsync_r;
   logic vsync_r;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hsync_r <= 1'b0;
         vsync_r <= 1'b0;
      end
      else
      begin
         hsync_r <= hsync_in && mc_run;
         vsync_r <= vsync_in && mc_run;
      end
   end
   assign hsync_out = hsync_r;
   assign vsync_out = vsync_r;

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sync_gate_a: assert property (!mc_run |=> !hsync_out && !vsync_out)
      else $error("sync active while controller held");
   offset_write_a: assert property (wr_xoff |=> row_offset[11:8] == $past(wdata[3:0]))
      else $error("extended offset nibble not taken");
   word_nowrap_a: assert property (mode_w == CAVC_MODE_WORD && mc_nowrap && mc_nors0 && mc_nors1
      |=> decoder_address_input == {$past(ma_r[14:0]), $past(ma_r[15])})
      else $error("word mode address wrong");
   word_wrap_a: assert property (mode_w == CAVC_MODE_WORD && !mc_nowrap
      |=> decoder_address_input[0] == $past(ma_r[13]))
      else $error("16 KB wrap not applied");
   dword_low_a: assert property (mode_w == CAVC_MODE_DWORD && mc_nors0 && mc_nors1
      |=> decoder_address_input == {$past(ma_r[13:0]), $past(ma_r[13:12])})
      else $error("doubleword address wrong");
   scan_sub_a: assert property (!mc_nors1 && !mc_nors0
      |=> decoder_address_input[14:13] == $past(row_scan[1:0]))
      else $error("row scan bits not substituted");
   quarter_rate_a: assert property (step_w && ul_quarter && !mc_half && !line_start
      ##1 !line_start |-> !step_w)
      else $error("counter advanced too soon");
   vblank_start_a: assert property (vadv_w && !frame_start && vnext_w == vbs_w |=> vblank)
      else $error("blanking did not start");
   half_retrace_a: assert property (hretrace && mc_hrdiv && !hr_phase_r && !frame_start
      |=> $stable(vcount_r))
      else $error("vertical counter not halved");
   underline_a: assert property (text_mode && row_scan == underline_and_count_mode_r[4:0]
      |=> underline_on)
      else $error("underline missing");

   dword_seen_c: cover property (mode_w == CAVC_MODE_DWORD ##1 step_w);
   vblank_rise_c: cover property (!vblank ##1 vblank);
   held_sync_c: cover property (!mc_run && hsync_in);
   underline_c: cover property (underline_on);

endmodule

/* core/cavc_defs.svh */
// constants for the crt address and vertical blanking control block
`ifndef CAVC_DEFS_SVH
`define CAVC_DEFS_SVH

// ==========================================
// register indices
`define CAVC_IDX_ROW_OFFSET_LOW 8'h13
`define CAVC_IDX_UNDERLINE_COUNT 8'h14
`define CAVC_IDX_VBLANK_START_LOW 8'h15
`define CAVC_IDX_VBLANK_END 8'h16
`define CAVC_IDX_CRT_MODE_CONTROL 8'h17
`define CAVC_IDX_EXT_VBLANK_START 8'h33
`define CAVC_IDX_EXT_ROW_OFFSET 8'h41

// ==========================================
// field positions
`define CAVC_UL_DWORD 6
`define CAVC_UL_QUARTER 5
`define CAVC_MC_RUN 7
`define CAVC_MC_BYTE 6
`define CAVC_MC_NOWRAP 5
`define CAVC_MC_HALF 3
`define CAVC_MC_HRDIV 2
`define CAVC_MC_NORS1 1
`define CAVC_MC_NORS0 0

// ==========================================
// reset values and read masks
`define CAVC_RST_BYTE 8'h00
`define CAVC_UL_RMASK 8'h7F
`define CAVC_MC_RMASK 8'hEF
`define CAVC_NIB_RMASK 8'h0F

`endif

/* core/cavc_pkg.sv */
// types shared by the crt address and vertical blanking control block
package cavc_pkg;
   typedef enum logic [1:0]
   {
      CAVC_MODE_BYTE = 2'b00,
      CAVC_MODE_WORD = 2'b01,
      CAVC_MODE_DWORD = 2'b10
   } cavc_mode_e;
endpackage
